// >>> core/tdm_sync_status_regs.sv
// frame sync status and terrestrial control register bank behind the two-wire port
// Function
// - per branch: preamble correlation real part, 8 bits
// - per branch: preamble correlation imaginary part, 8 bits
// - per branch: sync pattern correlation real part, 7 bits
// - per branch: sync pattern correlation imaginary part, 7 bits
// - phase code: 0 deg 00, 90 deg 10, 270 deg 01, 180 deg 11
// - status bits 6-5: idle, hunt, pattern resync, preamble resync
// - status bits 4-3: dropout class idle, short, medium, long
// - status bits 2-1 hold sync status, bit 0 holds lock
// - count preamble misses in presync window, or consecutive misses while synchronised
// - five terrestrial sub-block enable bits, all set after reset
// - after a find, search a symmetric window only, length reset 7
// - terrestrial presync detection when correlation reaches threshold, reset 2c
// - zero presync lost limit never declares loss of lock
module tdm_sync_status_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic        i_sat1_preamble_valid,
  input  wire logic [7:0]  i_sat1_preamble_corr_real,
  input  wire logic [7:0]  i_sat1_preamble_corr_imag,
  input  wire logic        i_sat1_pattern_valid,
  input  wire logic [6:0]  i_sat1_pattern_corr_real,
  input  wire logic [6:0]  i_sat1_pattern_corr_imag,
  input  wire logic [1:0]  i_sat1_phase_quadrant,
  input  wire logic        i_sat2_preamble_valid,
  input  wire logic [7:0]  i_sat2_preamble_corr_real,
  input  wire logic [7:0]  i_sat2_preamble_corr_imag,
  input  wire logic        i_sat2_pattern_valid,
  input  wire logic [6:0]  i_sat2_pattern_corr_real,
  input  wire logic [6:0]  i_sat2_pattern_corr_imag,
  input  wire logic [1:0]  i_sat2_phase_quadrant,
  input  wire logic        i_sat2_state_valid,
  input  wire logic [1:0]  i_sat2_acq_state,
  input  wire logic [1:0]  i_sat2_dropout_class,
  input  wire logic [1:0]  i_sat2_sync_status,
  input  wire logic        i_sat2_lock,
  input  wire logic        i_sat2_preamble_slot,
  input  wire logic        i_sat2_preamble_found,
  input  wire logic        i_terr_corr_valid,
  input  wire logic [7:0]  i_terr_corr,
  input  wire logic [7:0]  i_terr_offset,
  input  wire logic        i_terr_resync,
  output logic             o_terrestrial_fifo_enable,
  output logic             o_terrestrial_write_ctrl_enable,
  output logic             o_terrestrial_descramble_enable,
  output logic             o_terrestrial_format_enable,
  output logic             o_terrestrial_sync_enable,
  output logic [3:0]       o_terr_search_window_len,
  output logic             o_terr_in_window,
  output logic             o_terr_presync_detect,
  output logic             o_sat2_lock_lost
);

  // ----------
  // state
  // ----------
  typedef struct packed {
    logic [7:0] pre_re;
    logic [7:0] pre_im;
    logic [6:0] pat_re;
    logic [6:0] pat_im;
    logic [1:0] phase;
  } sat_corr_s;

  typedef struct packed {
    sat_corr_s [1:0] sat;
    logic [6:0]      s2_state;
    logic [3:0]      s2_miss_cnt;
    logic            s2_lost;
    logic [3:0]      presync_lim;
    logic [3:0]      sync_lim;
    logic [4:0]      enables;
    logic [3:0]      win_len;
    logic [6:0]      thresh;
    logic            terr_found;
    logic            terr_in_window;
    logic            terr_detect;
  } bank_s;

  bank_s        q;
  bank_s        d;
  logic         in_win;
  logic         det;
  logic [4:0]   miss_step_r;
  reg_access_if bus ();

  // ----------
  // functions
  // ----------
  // quadrant index to reported phase code
  function automatic logic [1:0] phase_code(input logic [1:0] quad);
    case (quad)
      tdm_sync_pkg::QUAD_0:   phase_code = tdm_sync_pkg::PHASE_0;
      tdm_sync_pkg::QUAD_90:  phase_code = tdm_sync_pkg::PHASE_90;
      tdm_sync_pkg::QUAD_180: phase_code = tdm_sync_pkg::PHASE_180;
      default:                phase_code = tdm_sync_pkg::PHASE_270;
    endcase
  endfunction

  // one missed preamble: returns {lost, new count}
  function automatic logic [4:0] miss_step(input logic [3:0] cnt, input logic [3:0] lim);
    logic [3:0] nxt;
    nxt = (cnt == tdm_sync_pkg::MISS_CNT_MAX) ? cnt : cnt + 4'h1;
    miss_step = {(lim != 4'h0) && (nxt >= lim), nxt};
  endfunction

  // offset from predicted position within the symmetric window
  function automatic logic window_hit(input logic [7:0] ofs, input logic [3:0] len);
    logic [7:0] mag;
    mag = ofs[7] ? (8'h00 - ofs) : ofs;
    window_hit = {1'b0, mag} <= {5'h00, len} >> 1;
  endfunction

  // register read mux, reserved bits and unmapped addresses read zero
  function automatic logic [7:0] read_byte(input logic [15:0] a, input bank_s s);
    case (a)
      tdm_sync_pkg::ADDR_SAT2_PRESYNC_LOST_LIMIT: read_byte = {4'h0, s.presync_lim};
      tdm_sync_pkg::ADDR_SAT2_SYNC_LOST_LIMIT:    read_byte = {4'h0, s.sync_lim};
      tdm_sync_pkg::ADDR_SAT1_PREAMBLE_CORR_REAL: read_byte = s.sat[0].pre_re;
      tdm_sync_pkg::ADDR_SAT1_PREAMBLE_CORR_IMAG: read_byte = s.sat[0].pre_im;
      tdm_sync_pkg::ADDR_SAT1_PATTERN_CORR_REAL:  read_byte = {1'b0, s.sat[0].pat_re};
      tdm_sync_pkg::ADDR_SAT1_PATTERN_CORR_IMAG:  read_byte = {1'b0, s.sat[0].pat_im};
      tdm_sync_pkg::ADDR_SAT1_DETECTED_PHASE:     read_byte = {6'h00, s.sat[0].phase};
      tdm_sync_pkg::ADDR_SAT2_SYNC_STATE:         read_byte = {1'b0, s.s2_state};
      tdm_sync_pkg::ADDR_SAT2_MISSED_COUNT:       read_byte = {4'h0, s.s2_miss_cnt};
      tdm_sync_pkg::ADDR_SAT2_PREAMBLE_CORR_REAL: read_byte = s.sat[1].pre_re;
      tdm_sync_pkg::ADDR_SAT2_PREAMBLE_CORR_IMAG: read_byte = s.sat[1].pre_im;
      tdm_sync_pkg::ADDR_SAT2_PATTERN_CORR_REAL:  read_byte = {1'b0, s.sat[1].pat_re};
      tdm_sync_pkg::ADDR_SAT2_PATTERN_CORR_IMAG:  read_byte = {1'b0, s.sat[1].pat_im};
      tdm_sync_pkg::ADDR_SAT2_DETECTED_PHASE:     read_byte = {6'h00, s.sat[1].phase};
      tdm_sync_pkg::ADDR_TERR_SUBBLOCK_ENABLES:   read_byte = {3'h0, s.enables};
      tdm_sync_pkg::ADDR_TERR_SEARCH_WINDOW_LEN:  read_byte = {4'h0, s.win_len};
      tdm_sync_pkg::ADDR_TERR_PRESYNC_THRESH:     read_byte = {1'b0, s.thresh};
      default:                                    read_byte = 8'h00;
    endcase
  endfunction

  // ----------
  // two-wire port
  // ----------
  i2c_reg_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_out  (o_sda_out),
    .o_sda_oe   (o_sda_oe),
    .bus        (bus.master)
  );

  // read data for the port
  always_comb begin
    bus.rdata = read_byte(bus.addr, q);
  end

  // ----------
  // next state
  // ----------
  always_comb begin
    d             = q;
    d.s2_lost     = 1'b0;
    d.terr_detect = 1'b0;
    miss_step_r   = 5'h00;

    // correlation results, latest one kept
    if (i_sat1_preamble_valid) begin
      d.sat[0].pre_re = i_sat1_preamble_corr_real;
      d.sat[0].pre_im = i_sat1_preamble_corr_imag;
    end
    if (i_sat1_pattern_valid) begin
      d.sat[0].pat_re = i_sat1_pattern_corr_real;
      d.sat[0].pat_im = i_sat1_pattern_corr_imag;
      d.sat[0].phase  = phase_code(i_sat1_phase_quadrant);
    end
    if (i_sat2_preamble_valid) begin
      d.sat[1].pre_re = i_sat2_preamble_corr_real;
      d.sat[1].pre_im = i_sat2_preamble_corr_imag;
    end
    if (i_sat2_pattern_valid) begin
      d.sat[1].pat_re = i_sat2_pattern_corr_real;
      d.sat[1].pat_im = i_sat2_pattern_corr_imag;
      d.sat[1].phase  = phase_code(i_sat2_phase_quadrant);
    end

    // satellite two status word
    if (i_sat2_state_valid) begin
      d.s2_state[tdm_sync_pkg::STAT_ACQ_LSB +: 2]     = i_sat2_acq_state;
      d.s2_state[tdm_sync_pkg::STAT_DROPOUT_LSB +: 2] = i_sat2_dropout_class;
      d.s2_state[tdm_sync_pkg::STAT_SYNC_LSB +: 2]    = i_sat2_sync_status;
      d.s2_state[tdm_sync_pkg::STAT_LOCK_BIT]         = i_sat2_lock;
    end

    // missed preamble counter, mode from reported sync status
    if (i_sat2_preamble_slot) begin
      case (q.s2_state[tdm_sync_pkg::STAT_SYNC_LSB +: 2])
        tdm_sync_pkg::SYNC_PRESYNC: begin
          if (!i_sat2_preamble_found) begin
            miss_step_r   = miss_step(q.s2_miss_cnt, q.presync_lim);
            d.s2_miss_cnt = miss_step_r[3:0];
            d.s2_lost     = miss_step_r[4];
          end
        end
        tdm_sync_pkg::SYNC_LOCKED: begin
          if (i_sat2_preamble_found) begin
            d.s2_miss_cnt = 4'h0;
          end else begin
            miss_step_r   = miss_step(q.s2_miss_cnt, q.sync_lim);
            d.s2_miss_cnt = miss_step_r[3:0];
            d.s2_lost     = miss_step_r[4];
          end
        end
        default: d.s2_miss_cnt = 4'h0;
      endcase
    end

    // terrestrial window and presync detection
    in_win = !q.terr_found || window_hit(i_terr_offset, q.win_len);
    det    = q.enables[tdm_sync_pkg::EN_SYNC_BIT] && i_terr_corr_valid && in_win
             && (i_terr_corr >= {1'b0, q.thresh});
    d.terr_in_window = in_win;
    d.terr_detect    = det;
    if (i_terr_resync || !q.enables[tdm_sync_pkg::EN_SYNC_BIT]) begin
      d.terr_found = 1'b0;
    end
    if (det) begin
      d.terr_found = 1'b1;
    end

    // host writes; read-only addresses fall to default
    if (bus.we) begin
      case (bus.addr)
        tdm_sync_pkg::ADDR_SAT2_PRESYNC_LOST_LIMIT: d.presync_lim = bus.wdata[3:0];
        tdm_sync_pkg::ADDR_SAT2_SYNC_LOST_LIMIT:    d.sync_lim = bus.wdata[3:0];
        tdm_sync_pkg::ADDR_TERR_SUBBLOCK_ENABLES:   d.enables = bus.wdata[4:0];
        tdm_sync_pkg::ADDR_TERR_SEARCH_WINDOW_LEN:  d.win_len = bus.wdata[3:0];
        tdm_sync_pkg::ADDR_TERR_PRESYNC_THRESH:     d.thresh = bus.wdata[6:0];
        default: ;
      endcase
    end
  end

  // ----------
  // state register
  // ----------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q             <= '0;
      q.presync_lim <= tdm_sync_pkg::RST_PRESYNC_LOST_LIMIT;
      q.sync_lim    <= tdm_sync_pkg::RST_SYNC_LOST_LIMIT;
      q.enables     <= tdm_sync_pkg::RST_SUBBLOCK_ENABLES;
      q.win_len     <= tdm_sync_pkg::RST_SEARCH_WINDOW_LEN;
      q.thresh      <= tdm_sync_pkg::RST_PRESYNC_THRESH;
    end else begin
      q <= d;
    end
  end

  // ----------
  // outputs
  // ----------
  // sub-block enables straight from the register
  assign o_terrestrial_fifo_enable       = q.enables[tdm_sync_pkg::EN_FIFO_BIT];
  assign o_terrestrial_write_ctrl_enable = q.enables[tdm_sync_pkg::EN_WRITE_CTRL_BIT];
  assign o_terrestrial_descramble_enable = q.enables[tdm_sync_pkg::EN_DESCRAMBLE_BIT];
  assign o_terrestrial_format_enable     = q.enables[tdm_sync_pkg::EN_FORMAT_BIT];
  assign o_terrestrial_sync_enable       = q.enables[tdm_sync_pkg::EN_SYNC_BIT];
  assign o_terr_search_window_len        = q.win_len;
  assign o_terr_in_window                = q.terr_in_window;
  assign o_terr_presync_detect           = q.terr_detect;
  assign o_sat2_lock_lost                = q.s2_lost;

endmodule

// >>> core/tdm_sync_pkg.sv
// constants, codes and register map of the frame sync status bank
package tdm_sync_pkg;

  // ----------
  // register byte addresses
  // ----------
  localparam logic [15:0] ADDR_SAT2_PRESYNC_LOST_LIMIT = 16'h0216;
  localparam logic [15:0] ADDR_SAT2_SYNC_LOST_LIMIT    = 16'h0217;
  localparam logic [15:0] ADDR_SAT1_PREAMBLE_CORR_REAL = 16'h0220;
  localparam logic [15:0] ADDR_SAT1_PREAMBLE_CORR_IMAG = 16'h0221;
  localparam logic [15:0] ADDR_SAT1_PATTERN_CORR_REAL  = 16'h0222;
  localparam logic [15:0] ADDR_SAT1_PATTERN_CORR_IMAG  = 16'h0223;
  localparam logic [15:0] ADDR_SAT1_DETECTED_PHASE     = 16'h0224;
  localparam logic [15:0] ADDR_SAT2_SYNC_STATE         = 16'h0225;
  localparam logic [15:0] ADDR_SAT2_MISSED_COUNT       = 16'h0226;
  localparam logic [15:0] ADDR_SAT2_PREAMBLE_CORR_REAL = 16'h0228;
  localparam logic [15:0] ADDR_SAT2_PREAMBLE_CORR_IMAG = 16'h0229;
  localparam logic [15:0] ADDR_SAT2_PATTERN_CORR_REAL  = 16'h022a;
  localparam logic [15:0] ADDR_SAT2_PATTERN_CORR_IMAG  = 16'h022b;
  localparam logic [15:0] ADDR_SAT2_DETECTED_PHASE     = 16'h022c;
  localparam logic [15:0] ADDR_TERR_SUBBLOCK_ENABLES   = 16'h022d;
  localparam logic [15:0] ADDR_TERR_SEARCH_WINDOW_LEN  = 16'h022e;
  localparam logic [15:0] ADDR_TERR_PRESYNC_THRESH     = 16'h022f;

  // ----------
  // reset values
  // ----------
  localparam logic [3:0] RST_PRESYNC_LOST_LIMIT = 4'h2;
  localparam logic [3:0] RST_SYNC_LOST_LIMIT    = 4'hb;
  localparam logic [4:0] RST_SUBBLOCK_ENABLES   = 5'h1f;
  localparam logic [3:0] RST_SEARCH_WINDOW_LEN  = 4'h7;
  localparam logic [6:0] RST_PRESYNC_THRESH     = 7'h2c;

  // ----------
  // field positions
  // ----------
  localparam int EN_FIFO_BIT       = 4;
  localparam int EN_WRITE_CTRL_BIT = 3;
  localparam int EN_DESCRAMBLE_BIT = 2;
  localparam int EN_FORMAT_BIT     = 1;
  localparam int EN_SYNC_BIT       = 0;
  localparam int STAT_ACQ_LSB      = 5;
  localparam int STAT_DROPOUT_LSB  = 3;
  localparam int STAT_SYNC_LSB     = 1;
  localparam int STAT_LOCK_BIT     = 0;

  // ----------
  // codes
  // ----------
  localparam logic [1:0] SYNC_IDLE     = 2'h0;
  localparam logic [1:0] SYNC_PRESYNC  = 2'h1;
  localparam logic [1:0] SYNC_LOCKED   = 2'h2;
  localparam logic [1:0] QUAD_0        = 2'h0;
  localparam logic [1:0] QUAD_90       = 2'h1;
  localparam logic [1:0] QUAD_180      = 2'h2;
  localparam logic [1:0] QUAD_270      = 2'h3;
  localparam logic [1:0] PHASE_0       = 2'h0;
  localparam logic [1:0] PHASE_90      = 2'h2;
  localparam logic [1:0] PHASE_180     = 2'h3;
  localparam logic [1:0] PHASE_270     = 2'h1;
  localparam logic [3:0] MISS_CNT_MAX  = 4'hf;

  // ----------
  // two-wire port framing
  // ----------
  localparam logic [1:0] PH_DEV        = 2'h0;
  localparam logic [1:0] PH_REG_HI     = 2'h1;
  localparam logic [1:0] PH_REG_LO     = 2'h2;
  localparam logic [1:0] PH_DATA       = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    I2C_IDLE   = 3'h0,
    I2C_RX     = 3'h1,
    I2C_ACK    = 3'h3,
    I2C_TX     = 3'h2,
    I2C_TX_ACK = 3'h6
  } i2c_state_e;

endpackage

// >>> core/reg_access_if.sv
// byte register access between the two-wire port and the register bank
interface reg_access_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic [7:0]  rdata;

  modport master (output addr, output wdata, output we, input rdata);
  modport target (input addr, input wdata, input we, output rdata);
endinterface

// >>> core/i2c_reg_port.sv
// two-wire slave port turning bus transactions into byte register accesses
module i2c_reg_port #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input  wire logic     i_core_clk,
  input  wire logic     i_reset,
  input  wire logic     i_scl,
  input  wire logic     i_sda,
  output logic          o_sda_out,
  output logic          o_sda_oe,
  reg_access_if.master  bus
);

  typedef struct packed {
    logic [2:0]              scl_sync;
    logic [2:0]              sda_sync;
    logic                    scl_f;
    logic                    sda_f;
    tdm_sync_pkg::i2c_state_e st;
    logic [3:0]              bit_cnt;
    logic [1:0]              phase;
    logic [7:0]              shift;
    logic                    rw;
    logic                    ack_seen;
    logic [15:0]             addr;
    logic [7:0]              wdata;
    logic                    we;
    logic                    sda_out;
    logic                    sda_oe;
  } port_s;

  port_s q;
  port_s d;
  logic  scl_n;
  logic  sda_n;
  logic  scl_rise;
  logic  scl_fall;
  logic  start_c;
  logic  stop_c;

  // ----------
  // next state
  // ----------
  // pins filtered: a level counts once stages two and three agree
  always_comb begin
    scl_n    = (q.scl_sync[1] == q.scl_sync[2]) ? q.scl_sync[2] : q.scl_f;
    sda_n    = (q.sda_sync[1] == q.sda_sync[2]) ? q.sda_sync[2] : q.sda_f;
    scl_rise = scl_n & ~q.scl_f;
    scl_fall = ~scl_n & q.scl_f;
    start_c  = q.scl_f & scl_n & q.sda_f & ~sda_n;
    stop_c   = q.scl_f & scl_n & ~q.sda_f & sda_n;
    d          = q;
    d.scl_sync = {q.scl_sync[1:0], i_scl};
    d.sda_sync = {q.sda_sync[1:0], i_sda};
    d.scl_f    = scl_n;
    d.sda_f    = sda_n;
    d.we       = 1'b0;
    if (start_c) begin
      d.st      = tdm_sync_pkg::I2C_RX;
      d.bit_cnt = 4'h0;
      d.phase   = tdm_sync_pkg::PH_DEV;
      d.sda_oe  = 1'b0;
    end else if (stop_c) begin
      d.st     = tdm_sync_pkg::I2C_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        tdm_sync_pkg::I2C_RX: begin
          if (scl_rise) begin
            d.shift   = {q.shift[6:0], sda_n};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == tdm_sync_pkg::BITS_PER_BYTE) begin
            d.sda_oe = 1'b1;
            d.st     = tdm_sync_pkg::I2C_ACK;
            case (q.phase)
              tdm_sync_pkg::PH_DEV: begin
                d.rw = q.shift[0];
                if (q.shift[7:1] != DEV_ADDR) begin
                  d.sda_oe = 1'b0;
                  d.st     = tdm_sync_pkg::I2C_IDLE;
                end
              end
              tdm_sync_pkg::PH_REG_HI: d.addr[15:8] = q.shift;
              tdm_sync_pkg::PH_REG_LO: d.addr[7:0] = q.shift;
              default: begin
                d.wdata = q.shift;
                d.we    = 1'b1;
              end
            endcase
          end
        end
        tdm_sync_pkg::I2C_ACK: begin
          if (scl_fall) begin
            d.sda_oe  = 1'b0;
            d.bit_cnt = 4'h0;
            d.st      = tdm_sync_pkg::I2C_RX;
            if (q.phase == tdm_sync_pkg::PH_DEV && q.rw) begin
              d.shift   = bus.rdata;
              d.sda_oe  = ~bus.rdata[7];
              d.bit_cnt = 4'h1;
              d.addr    = q.addr + 16'h0001;
              d.st      = tdm_sync_pkg::I2C_TX;
            end else if (q.phase == tdm_sync_pkg::PH_DATA) begin
              d.addr = q.addr + 16'h0001;
            end else begin
              d.phase = q.phase + 2'h1;
            end
          end
        end
        tdm_sync_pkg::I2C_TX: begin
          if (scl_fall) begin
            if (q.bit_cnt == tdm_sync_pkg::BITS_PER_BYTE) begin
              d.sda_oe = 1'b0;
              d.st     = tdm_sync_pkg::I2C_TX_ACK;
            end else begin
              d.sda_oe  = ~q.shift[6];
              d.shift   = {q.shift[6:0], 1'b0};
              d.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        tdm_sync_pkg::I2C_TX_ACK: begin
          if (scl_rise) begin
            d.ack_seen = ~sda_n;
          end else if (scl_fall) begin
            d.st = tdm_sync_pkg::I2C_IDLE;
            if (q.ack_seen) begin
              d.shift   = bus.rdata;
              d.sda_oe  = ~bus.rdata[7];
              d.bit_cnt = 4'h1;
              d.addr    = q.addr + 16'h0001;
              d.st      = tdm_sync_pkg::I2C_TX;
            end
          end
        end
        default: d.st = tdm_sync_pkg::I2C_IDLE;
      endcase
    end
  end

  // ----------
  // state register
  // ----------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q          <= '0;
      q.scl_sync <= 3'h7;
      q.sda_sync <= 3'h7;
      q.scl_f    <= 1'b1;
      q.sda_f    <= 1'b1;
      q.st       <= tdm_sync_pkg::I2C_IDLE;
    end else begin
      q <= d;
    end
  end

  assign o_sda_out = q.sda_out;
  assign o_sda_oe  = q.sda_oe;
  assign bus.addr  = q.addr;
  assign bus.wdata = q.wdata;
  assign bus.we    = q.we;

endmodule

// >>> tb/tdm_sync_status_regs_assertions.sv
// assertion checker bound to the frame sync status register bank
module tdm_sync_status_regs_assertions (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_sat2_preamble_slot,
  input wire logic       i_sat2_preamble_found,
  input wire logic       i_terr_corr_valid,
  input wire logic [7:0] i_terr_offset,
  input wire logic       i_terr_resync,
  input wire logic       o_terrestrial_fifo_enable,
  input wire logic       o_terrestrial_sync_enable,
  input wire logic [3:0] o_terr_search_window_len,
  input wire logic       o_terr_in_window,
  input wire logic       o_terr_presync_detect,
  input wire logic       o_sat2_lock_lost
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // resync with no detection in flight for two cycles
  sequence s_resync; i_terr_resync && !i_terr_corr_valid ##1 !i_terr_corr_valid; endsequence
  property p_rst; $past(i_reset) |-> o_terr_search_window_len == 4'h7 && o_terrestrial_fifo_enable; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_det_cause; o_terr_presync_detect |-> $past(i_terr_corr_valid); endproperty
  a_det_cause: assert property (p_det_cause) else $error("detect without sample");
  property p_no_det; !i_terr_corr_valid |=> !o_terr_presync_detect; endproperty
  a_no_det: assert property (p_no_det) else $error("stray detect");
  property p_sync_off; !o_terrestrial_sync_enable |=> !o_terr_presync_detect; endproperty
  a_sync_off: assert property (p_sync_off) else $error("detect while disabled");
  property p_lost_cause; o_sat2_lock_lost |-> $past(i_sat2_preamble_slot) && !$past(i_sat2_preamble_found); endproperty
  a_lost_cause: assert property (p_lost_cause) else $error("loss without miss");
  property p_no_lost; !i_sat2_preamble_slot |=> !o_sat2_lock_lost; endproperty
  a_no_lost: assert property (p_no_lost) else $error("stray loss");
  property p_centre; i_terr_offset == 8'h00 |=> o_terr_in_window; endproperty
  a_centre: assert property (p_centre) else $error("centre outside window");
  property p_resync; s_resync |=> o_terr_in_window; endproperty
  a_resync: assert property (p_resync) else $error("window kept after resync");
endmodule
bind tdm_sync_status_regs tdm_sync_status_regs_assertions tdm_sync_status_regs_assertions_i (.*);

// >>> tb/tdm_sync_status_regs_tb.sv
// self-checking bench for the frame sync status register bank
module tdm_sync_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // signals, satellite two mirrors one inverted, phase quadrant one step on
  // ----------
  logic i_core_clk = 0, i_reset = 1, i_scl = 1, m_sda = 1, o_sda_out, o_sda_oe, o_sat2_lock_lost;
  logic i_sat1_preamble_valid = 0, i_sat1_pattern_valid = 0, i_sat2_state_valid = 0;
  logic i_sat2_preamble_slot = 0, i_sat2_preamble_found = 0, i_terr_corr_valid = 0;
  logic i_terr_resync = 0, o_terr_in_window, o_terr_presync_detect, o_terrestrial_sync_enable;
  logic o_terrestrial_fifo_enable, o_terrestrial_write_ctrl_enable;
  logic o_terrestrial_descramble_enable, o_terrestrial_format_enable;
  logic [7:0] i_sat1_preamble_corr_real = '0, i_sat1_preamble_corr_imag = '0, i_terr_corr = '0;
  logic [7:0] i_terr_offset = '0, q;
  logic [6:0] i_sat1_pattern_corr_real = '0, i_sat1_pattern_corr_imag = '0, v = '0;
  logic [1:0] i_sat1_phase_quadrant = '0, ph [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [3:0] o_terr_search_window_len;
  int fails = 0, comparisons = 0, cyc = 0, det = 0, lost = 0;
  wire i_sda = m_sda & !o_sda_oe;
  wire i_sat2_preamble_valid = i_sat1_preamble_valid, i_sat2_pattern_valid = i_sat1_pattern_valid;
  wire [7:0] i_sat2_preamble_corr_real = ~i_sat1_preamble_corr_real;
  wire [7:0] i_sat2_preamble_corr_imag = ~i_sat1_preamble_corr_imag;
  wire [6:0] i_sat2_pattern_corr_real = ~i_sat1_pattern_corr_real;
  wire [6:0] i_sat2_pattern_corr_imag = ~i_sat1_pattern_corr_imag;
  wire [1:0] i_sat2_phase_quadrant = i_sat1_phase_quadrant + 2'h1;
  wire [1:0] i_sat2_acq_state = v[6:5], i_sat2_dropout_class = v[4:3], i_sat2_sync_status = v[2:1];
  wire i_sat2_lock = v[0];
  tdm_sync_status_regs tdm_sync_status_regs_i (.*);
  always #25 i_core_clk = ~i_core_clk;
  // pulse counters and hang guard
  always @(posedge i_core_clk) begin
    det += o_terr_presync_detect;
    lost += o_sat2_lock_lost;
    if (++cyc == 90000) begin fails++; summarize(); end
  end
  task automatic w(int n); repeat (n) @(posedge i_core_clk); #5; endtask
  task automatic chk(string n, logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin fails++; $display("CHECK FAILED %s expected %h seen %h", n, e, s); end
  endtask
  // two-wire bit: data moved mid-low, sampled mid-high
  task automatic bt(logic b, output logic r);
    w(4); m_sda = b; w(4); i_scl = 1; w(4); r = i_sda; w(4); i_scl = 0;
  endtask
  task automatic start(); w(4); m_sda = 1; w(4); i_scl = 1; w(8); m_sda = 0; w(8); i_scl = 0; endtask
  task automatic stop(); w(4); m_sda = 0; w(4); i_scl = 1; w(8); m_sda = 1; w(8); endtask
  task automatic xb(logic [7:0] d, logic m);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(m, r);
    if (d !== 8'hff) chk("ack", 8'h00, {7'h0, r});
  endtask
  task automatic sel(logic [15:0] a); start(); xb(8'h40, 1); xb(a[15:8], 1); xb(a[7:0], 1); endtask
  task automatic wr(logic [15:0] a, logic [7:0] d); sel(a); xb(d, 1); stop(); endtask
  task automatic rchk(logic [15:0] a, logic [7:0] e);
    sel(a); start(); xb(8'h41, 1); xb(8'hff, 1); stop();
    chk($sformatf("reg %h", a), e, q);
    chk("sda out", 8'h00, {7'h0, o_sda_out}); // open drain level
  endtask
  task automatic slot(logic f); i_sat2_preamble_found = f; i_sat2_preamble_slot = 1; w(1); i_sat2_preamble_slot = 0; w(2); endtask
  task automatic tc(logic [7:0] c); i_terr_corr = c; i_terr_corr_valid = 1; w(1); i_terr_corr_valid = 0; w(2); endtask
  task automatic st(logic [6:0] s); v = s; i_sat2_state_valid = 1; w(1); i_sat2_state_valid = 0; endtask
  task automatic t_reset();
    rchk(16'h0216, 8'h02);
    rchk(16'h022d, 8'h1f); // enables
    rchk(16'h022e, 8'h07); // window
    rchk(16'h022f, 8'h2c); // threshold
    rchk(16'h0227, 8'h00); // unmapped
  endtask
  task automatic t_capture();
    i_sat1_preamble_corr_real = 8'ha5; i_sat1_preamble_corr_imag = 8'h3c;
    i_sat1_pattern_corr_real = 7'h55; i_sat1_pattern_corr_imag = 7'h2a;
    i_sat1_preamble_valid = 1; w(1); i_sat1_preamble_valid = 0; i_sat1_preamble_corr_real = 8'h00;
    wr(16'h0220, 8'h00);
    rchk(16'h0220, 8'ha5); // held, write ignored
    rchk(16'h0229, 8'hc3); // branch two
    for (int k = 0; k < 4; k++) begin
      i_sat1_phase_quadrant = 2'(k); i_sat1_pattern_valid = 1; w(1); i_sat1_pattern_valid = 0;
      rchk(16'h0224, {6'h0, ph[k]}); // phase one
      rchk(16'h022c, {6'h0, ph[(k + 1) % 4]}); // phase two
    end
    rchk(16'h0222, 8'h55); // pattern real
    rchk(16'h022b, 8'h55); // pattern imag
  endtask
  task automatic t_status();
    for (int k = 0; k < 4; k++) begin
      st({2'(k), ~2'(k), 2'(k) ^ 2'h1, k[0]});
      rchk(16'h0225, {1'b0, v}); // status fields
    end
  endtask
  task automatic t_miss();
    st(7'h05); wr(16'h0217, 8'h02); slot(1); slot(0); slot(0);
    chk("lock lost", 8'h01, 8'(lost)); // limit reached
    rchk(16'h0226, 8'h02); // miss count
    slot(1);
    rchk(16'h0226, 8'h00); // found clears
    wr(16'h0216, 8'h00); st(7'h02); repeat (3) slot(0);
    chk("lock lost", 8'h01, 8'(lost)); // zero limit
    rchk(16'h0226, 8'h03); // presync count
  endtask
  task automatic t_terr();
    wr(16'h022f, 8'h10); tc(8'h0f);
    chk("detect", 8'h00, 8'(det)); // below threshold
    tc(8'h10);
    chk("detect", 8'h01, 8'(det)); // equal
    i_terr_offset = 8'h04; tc(8'h7f);
    chk("detect", 8'h01, 8'(det)); // outside window
    i_terr_offset = 8'hfd; w(2);
    chk("in window", 8'h01, {7'h0, o_terr_in_window}); // edge of window
    i_terr_resync = 1; w(1); i_terr_resync = 0; i_terr_offset = 8'h04; w(2);
    chk("in window", 8'h01, {7'h0, o_terr_in_window}); // search anywhere
    wr(16'h022e, 8'h09); tc(8'h10); w(1);
    chk("window len", 8'h09, {4'h0, o_terr_search_window_len});
    chk("in window", 8'h01, {7'h0, o_terr_in_window}); // wider window
    wr(16'h022d, 8'h1e);
    chk("enables", 8'h1e, {3'h0, o_terrestrial_fifo_enable, o_terrestrial_write_ctrl_enable,
      o_terrestrial_descramble_enable, o_terrestrial_format_enable, o_terrestrial_sync_enable});
    tc(8'h7f);
    chk("detect", 8'h02, 8'(det)); // sync disabled
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    w(2); i_reset = 0; w(4);
    t_reset(); t_capture(); t_status(); t_miss(); t_terr();
    summarize();
  end
endmodule
